// File: hw/rqh_pkg.sv
// types of the queue head removal sequencer
// assumes rqh_regs.svh supplies the numeric constants
package rqh_pkg;
    typedef enum logic [1:0] {rqh_long_checked, rqh_long_resident, rqh_quad_checked} rqh_variant_t;
    typedef enum logic [2:0] {rqh_mem_read, rqh_mem_locked, rqh_mem_cond, rqh_mem_write,
                              rqh_mem_barrier, rqh_mem_probe_rd, rqh_mem_probe_wr} rqh_op_t;
    typedef enum logic [1:0] {rqh_exc_none, rqh_exc_illegal_operand, rqh_exc_mm_fault} rqh_exc_t;
    typedef enum logic [2:0] {rqh_mm_ok, rqh_mm_access_violation, rqh_mm_fault_on_read,
                              rqh_mm_fault_on_write, rqh_mm_translation_not_valid} rqh_mm_t;
    typedef struct packed
    {
        rqh_op_t     op;
        logic [63:0] addr;
        logic [63:0] wdata;
        logic        long_word;
    } rqh_mem_req_t;
    typedef struct packed
    {
        logic [63:0] rdata;
        logic        cond_ok;
        rqh_mm_t     mm;
    } rqh_mem_rsp_t;
endpackage : rqh_pkg

// File: hw/rqh_regs.svh
// constants of the queue head removal sequencer
// assumes a 64-bit address space and a 64-bit memory data path
`ifndef RQH_REGS_SVH
`define RQH_REGS_SVH
`define RQH_STAT_BUSY      64'hffffffffffffffff
`define RQH_STAT_EMPTY     64'h0000000000000000
`define RQH_STAT_MORE      64'h0000000000000001
`define RQH_STAT_NOW_EMPTY 64'h0000000000000002
`define RQH_LINK_BACK_LONG 64'h0000000000000004
`define RQH_LINK_BACK_QUAD 64'h0000000000000008
`define RQH_ALIGN_LONG     64'h0000000000000007
`define RQH_ALIGN_QUAD     64'h000000000000000f
`define RQH_LOCK_BIT       64'h0000000000000001
`define RQH_RETRY_DEF      8'h10
`endif

// File: hw/rqh_remove_head.sv
// sequencer removing the entry after the header of a self-relative queue
// assumes a memory system answering one request at a time with rsp_valid
`timescale 1ns/1ps
`include "rqh_regs.svh"
module rqh_remove_head
    import rqh_pkg::*;
#(
    parameter logic [7:0] RETRY_COUNT = `RQH_RETRY_DEF
)
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         start,
    input  wire rqh_variant_t variant,
    input  wire logic [63:0]  header_address_operand,
    output logic              busy,
    output logic              done,
    output logic [63:0]       status_result,
    output logic [63:0]       removed_entry_result,
    output rqh_exc_t          exception,
    output rqh_mm_t           mm_cause,
    output logic              req_valid,
    output rqh_mem_req_t      req,
    input  wire logic         rsp_valid,
    input  wire rqh_mem_rsp_t rsp
);

    typedef enum logic [3:0] {st_idle, st_lock_load, st_cond_store, st_barrier1, st_probe_hdr,
                              st_read_entry, st_probe_entry, st_probe_succ, st_write_back,
                              st_barrier2, st_write_fwd, st_restore, st_finish} rqh_state_t;

    rqh_state_t   state;
    rqh_variant_t var_q;
    logic [63:0]  hdr;
    logic [63:0]  tmp0;
    logic [63:0]  entry;
    logic [63:0]  succ;
    logic [7:0]   retries;
    rqh_exc_t     pend_exc;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [63:0] sext32(input logic [63:0] v);
        return {{32{v[31]}}, v[31:0]};
    endfunction : sext32

    // alignment mask of the link size; long queues use quadword-aligned links
    function automatic logic [63:0] align_mask(input rqh_variant_t v);
        return (v == rqh_quad_checked) ? `RQH_ALIGN_QUAD : `RQH_ALIGN_LONG;
    endfunction : align_mask

    function automatic logic is_long(input rqh_variant_t v);
        return v != rqh_quad_checked;
    endfunction : is_long

    // long offsets wrap in 32 bits then sign-extend
    function automatic logic [63:0] link_add(input rqh_variant_t v, input logic [63:0] a,
                                             input logic [63:0] b);
        return is_long(v) ? sext32(a + sext32(b)) : a + b;
    endfunction : link_add

    ////////////////////////////////////////////////////////////////////////////
    logic [63:0] offset;
    logic        misaligned_entry;
    logic        checked;
    assign offset           = is_long(var_q) ? sext32(tmp0) : tmp0;
    assign checked          = var_q != rqh_long_resident;
    assign misaligned_entry = checked && ((offset & align_mask(var_q)) != 64'h0);
    assign busy             = state != st_idle;

    // one request at a time; the engine ignores start while busy so it cannot be interrupted
    always_comb
    begin
        req_valid     = 1'b1;
        req           = '0;
        req.long_word = is_long(var_q);
        case (state)
            st_lock_load:
            begin
                req.op   = rqh_mem_locked;
                req.addr = hdr;
            end
            st_cond_store:
            begin
                req.op    = rqh_mem_cond;
                req.addr  = hdr;
                req.wdata = tmp0 | `RQH_LOCK_BIT;
            end
            st_barrier1, st_barrier2:
                req.op = rqh_mem_barrier;
            st_probe_hdr:
            begin
                req.op   = rqh_mem_probe_wr;
                req.addr = hdr;
            end
            st_read_entry:
            begin
                req.op   = rqh_mem_read;
                req.addr = entry;
            end
            st_probe_entry:
            begin
                req.op   = rqh_mem_probe_rd;
                req.addr = entry;
            end
            st_probe_succ:
            begin
                req.op   = rqh_mem_probe_wr;
                req.addr = succ + (is_long(var_q) ? `RQH_LINK_BACK_LONG : `RQH_LINK_BACK_QUAD);
            end
            st_write_back:
            begin
                req.op    = rqh_mem_write;
                req.addr  = succ + (is_long(var_q) ? `RQH_LINK_BACK_LONG : `RQH_LINK_BACK_QUAD);
                req.wdata = hdr - succ;
            end
            st_write_fwd:
            begin
                req.op    = rqh_mem_write;
                req.addr  = hdr;
                req.wdata = succ - hdr;
            end
            st_restore:
            begin
                req.op    = rqh_mem_write;
                req.addr  = hdr;
                req.wdata = tmp0;
            end
            default:
                req_valid = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence; the locked header is held until the forward write or restore, which
    // keeps other interlocked updaters out for the whole removal
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (!resetn)
        begin
            state                <= st_idle;
            var_q                <= rqh_long_checked;
            hdr                  <= 64'h0;
            tmp0                 <= 64'h0;
            entry                <= 64'h0;
            succ                 <= 64'h0;
            retries              <= 8'h0;
            pend_exc             <= rqh_exc_none;
            status_result        <= 64'h0;
            removed_entry_result <= 64'h0;
            exception            <= rqh_exc_none;
            mm_cause             <= rqh_mm_ok;
            done                 <= 1'b0;
        end
        else
        begin
            case (state)
                st_idle:
                    if (start)
                    begin
                        var_q     <= variant;
                        hdr       <= header_address_operand;
                        retries   <= RETRY_COUNT;
                        exception <= rqh_exc_none;
                        mm_cause  <= rqh_mm_ok;
                        if ((variant == rqh_long_checked &&
                             ((header_address_operand & `RQH_ALIGN_LONG) != 64'h0 ||
                              sext32(header_address_operand) != header_address_operand)) ||
                            (variant == rqh_quad_checked &&
                             (header_address_operand & `RQH_ALIGN_QUAD) != 64'h0))
                        begin
                            exception <= rqh_exc_illegal_operand;
                            state     <= st_finish;
                        end
                        else
                            state <= st_lock_load;
                    end
                st_lock_load:
                    if (rsp_valid)
                    begin
                        tmp0 <= rsp.rdata;
                        if ((rsp.rdata & `RQH_LOCK_BIT) != 64'h0)
                        begin
                            status_result <= `RQH_STAT_BUSY;
                            state         <= st_finish;
                        end
                        else
                            state <= st_cond_store;
                    end
                st_cond_store:
                    if (rsp_valid)
                    begin
                        if (rsp.cond_ok)
                            state <= st_barrier1;
                        else if (retries <= 8'h1)
                        begin
                            status_result <= `RQH_STAT_BUSY;
                            state         <= st_finish;
                        end
                        else
                        begin
                            retries <= retries - 8'h1;
                            state   <= st_lock_load;
                        end
                    end
                st_barrier1:
                    if (rsp_valid)
                    begin
                        entry <= link_add(var_q, hdr, tmp0);
                        if (misaligned_entry)
                        begin
                            pend_exc <= rqh_exc_illegal_operand;
                            state    <= st_restore;
                        end
                        else if (checked)
                            state <= st_probe_hdr;
                        else if (offset == 64'h0)
                        begin
                            succ  <= hdr;
                            state <= st_write_back;
                        end
                        else
                            state <= st_read_entry;
                    end
                st_probe_hdr:
                    if (rsp_valid)
                    begin
                        if (rsp.mm != rqh_mm_ok)
                        begin
                            mm_cause <= rsp.mm;
                            pend_exc <= rqh_exc_mm_fault;
                            state    <= st_restore;
                        end
                        else if (offset == 64'h0)
                        begin
                            succ  <= hdr;
                            state <= st_write_back;
                        end
                        else
                            state <= st_probe_entry;
                    end
                st_probe_entry:
                    if (rsp_valid)
                    begin
                        if (rsp.mm != rqh_mm_ok)
                        begin
                            mm_cause <= rsp.mm;
                            pend_exc <= rqh_exc_mm_fault;
                            state    <= st_restore;
                        end
                        else
                            state <= st_read_entry;
                    end
                st_read_entry:
                    if (rsp_valid)
                    begin
                        succ <= link_add(var_q, entry, rsp.rdata);
                        if ((link_add(var_q, entry, rsp.rdata) & align_mask(var_q)) != 64'h0
                            && checked)
                        begin
                            pend_exc <= rqh_exc_illegal_operand;
                            state    <= st_restore;
                        end
                        else
                            state <= checked ? st_probe_succ : st_write_back;
                    end
                st_probe_succ:
                    if (rsp_valid)
                    begin
                        if (rsp.mm != rqh_mm_ok)
                        begin
                            mm_cause <= rsp.mm;
                            pend_exc <= rqh_exc_mm_fault;
                            state    <= st_restore;
                        end
                        else
                            state <= st_write_back;
                    end
                st_write_back:
                    if (rsp_valid)
                        state <= st_barrier2;
                st_barrier2:
                    if (rsp_valid)
                        state <= st_write_fwd;
                st_write_fwd:
                    if (rsp_valid)
                    begin
                        removed_entry_result <= entry;
                        if (offset == 64'h0)
                            status_result <= `RQH_STAT_EMPTY;
                        else if (succ == hdr)
                            status_result <= `RQH_STAT_NOW_EMPTY;
                        else
                            status_result <= `RQH_STAT_MORE;
                        state <= st_finish;
                    end
                st_restore:
                    if (rsp_valid)
                    begin
                        exception <= pend_exc;
                        state     <= st_finish;
                    end
                st_finish:
                begin
                    done  <= 1'b1;
                    state <= st_idle;
                end
                default:
                    state <= st_idle;
            endcase
        end
    end

endmodule : rqh_remove_head

// File: test/rqh_mem_model.sv
// memory system model answering the sequencer one request at a time
// assumes the bench sets m, lat, cond_fail and fault_kind by hierarchy
`timescale 1ns/1ps
module rqh_mem_model
    import rqh_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         req_valid,
    input  wire rqh_mem_req_t req,
    output logic              rsp_valid,
    output rqh_mem_rsp_t      rsp
);
    logic [31:0] m [logic [63:0]];
    int          lat = 0;
    int          cnt = 0;
    int          cond_fail = 0;
    rqh_mm_t     fault_kind = rqh_mm_ok;

    function automatic logic [31:0] rd(input logic [63:0] a);
        return m.exists(a) ? m[a] : 32'h0;
    endfunction : rd

    // a long write touches the low word only
    task automatic wr(input logic [63:0] a, input logic [63:0] d, input logic lw);
        m[a] = d[31:0];
        if (!lw)
            m[a + 64'h4] = d[63:32];
    endtask : wr

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rsp_valid <= 1'h0;
            rsp <= '0;
            cnt <= 0;
        end
        else if (rsp_valid || !req_valid)
        begin
            rsp_valid <= 1'h0;
            // idle data wanders so a stale value cannot pass for an answer
            rsp.rdata <= ~rsp.rdata;
        end
        else if (cnt < lat)
            cnt <= cnt + 1;
        else
        begin
            cnt <= 0;
            rsp_valid <= 1'h1;
            rsp.rdata <= {rd(req.addr + 64'h4), rd(req.addr)};
            rsp.cond_ok <= (cond_fail == 0);
            rsp.mm <= (req.op inside {rqh_mem_probe_rd, rqh_mem_probe_wr}) ? fault_kind : rqh_mm_ok;
            if (req.op == rqh_mem_cond && cond_fail > 0)
                cond_fail = cond_fail - 1;
            else if (req.op == rqh_mem_cond || req.op == rqh_mem_write)
                wr(req.addr, req.wdata, req.long_word);
        end
    end
endmodule : rqh_mem_model

// File: test/rqh_remove_head_chk.sv
// assertions on the ports of the queue head removal sequencer
// assumes it is bound into rqh_remove_head
`timescale 1ns/1ps
`include "rqh_regs.svh"
module rqh_remove_head_chk
    import rqh_pkg::*;
#(
    parameter logic [7:0] RETRY_COUNT = `RQH_RETRY_DEF
)
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire logic         start,
    input wire rqh_variant_t variant,
    input wire logic [63:0]  header_address_operand,
    input wire logic         busy,
    input wire logic         done,
    input wire logic [63:0]  status_result,
    input wire logic [63:0]  removed_entry_result,
    input wire rqh_exc_t     exception,
    input wire rqh_mm_t      mm_cause,
    input wire logic         req_valid,
    input wire rqh_mem_req_t req,
    input wire logic         rsp_valid,
    input wire rqh_mem_rsp_t rsp
);
    logic [63:0]  hdr_q;
    logic [63:0]  ll_q;
    rqh_variant_t var_q;
    logic         locked_q;
    logic [3:0]   mb;
    logic [8:0]   nc;
    logic         wr_v;
    assign wr_v = req_valid && req.op == rqh_mem_write;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!resetn || (start && !busy))
        begin
            hdr_q <= header_address_operand;
            var_q <= variant;
            locked_q <= 1'h0;
            mb <= 4'h0;
            nc <= 9'h0;
        end
        else if (rsp_valid && req_valid)
        begin
            if (req.op == rqh_mem_locked)
                ll_q <= rsp.rdata;
            if (req.op == rqh_mem_cond)
                nc <= nc + 9'h1;
            if (req.op == rqh_mem_cond && rsp.cond_ok)
                locked_q <= 1'h1;
            if (req.op == rqh_mem_barrier)
                mb <= mb + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    ll_addr_a: assert property (
        req_valid && req.op == rqh_mem_locked |-> req.addr == hdr_q) else $error("locked load addr");
    lock_end_a: assert property (
        rsp_valid && req_valid && req.op == rqh_mem_locked && rsp.rdata[0]
        |-> ##[1:3] done && status_result == `RQH_STAT_BUSY) else $error("set lock not refused");
    cond_data_a: assert property (
        req_valid && req.op == rqh_mem_cond
        |-> req.wdata[31:0] == (ll_q[31:0] | 32'h1) && req.addr == hdr_q) else $error("cond data");
    retry_max_a: assert property (
        nc <= {1'h0, RETRY_COUNT}) else $error("too many retries");
    write_locked_a: assert property (
        wr_v |-> locked_q && mb != 4'h0) else $error("write without lock or barrier");
    hdr_free_a: assert property (
        wr_v && req.addr == hdr_q |-> !req.wdata[0]) else $error("header write keeps lock");
    back_off_a: assert property (
        wr_v && req.addr != hdr_q |-> (var_q == rqh_quad_checked ? req.addr[3:0] == 4'h8
        : req.addr[2:0] == 3'h4)) else $error("back link offset");
    long_word_a: assert property (
        wr_v |-> req.long_word == (var_q != rqh_quad_checked)) else $error("write width");
    quad_ill_a: assert property (
        start && !busy && variant == rqh_quad_checked && header_address_operand[3:0] != 4'h0
        |-> ##[1:3] done && exception == rqh_exc_illegal_operand) else $error("quad header");
    long_ill_a: assert property (
        start && !busy && variant == rqh_long_checked && (header_address_operand[2:0] != 3'h0
        || header_address_operand[63:32] != {32{header_address_operand[31]}})
        |-> ##[1:3] done && exception == rqh_exc_illegal_operand) else $error("long header");
    mm_fault_a: assert property (
        rsp_valid && req_valid && req.op inside {rqh_mem_probe_rd, rqh_mem_probe_wr}
        && rsp.mm != rqh_mm_ok |-> ##[1:40] done && exception == rqh_exc_mm_fault)
        else $error("probe fault lost");
endmodule : rqh_remove_head_chk

bind rqh_remove_head rqh_remove_head_chk #(.RETRY_COUNT(RETRY_COUNT)) u_rqh_remove_head_chk
(
    .clk(clk), .resetn(resetn), .start(start), .variant(variant),
    .header_address_operand(header_address_operand), .busy(busy), .done(done),
    .status_result(status_result), .removed_entry_result(removed_entry_result),
    .exception(exception), .mm_cause(mm_cause), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp)
);

// File: test/rqh_remove_head_tb.sv
// self-checking bench of the queue head removal sequencer
// assumes the memory model and the bound checker are compiled first
`timescale 1ns/1ps
`include "rqh_regs.svh"
`define MEM u_rqh_mem_model
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) \
    begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module rqh_remove_head_tb;
    import rqh_pkg::*;
    localparam logic [7:0]  RETRY = 8'h04;
    localparam logic [63:0] H     = 64'h1000;
    localparam logic [63:0] Q     = 64'h2000;
    logic         clk = 1'h0;
    logic         resetn = 1'h0;
    logic         start = 1'h0;
    rqh_variant_t variant = rqh_long_checked;
    logic [63:0]  hdr = 64'h0;
    logic         busy, done, req_valid, rsp_valid;
    logic [63:0]  status_result, removed_entry_result;
    rqh_exc_t     exception;
    rqh_mm_t      mm_cause;
    rqh_mem_req_t req;
    rqh_mem_rsp_t rsp;
    int           errors = 0;
    int           checks_done = 0;
    int           cycles = 0;
    always #5 clk = ~clk;
    rqh_remove_head #(.RETRY_COUNT(RETRY)) u_rqh_remove_head (.clk(clk), .resetn(resetn),
        .start(start), .variant(variant), .header_address_operand(hdr), .busy(busy),
        .done(done), .status_result(status_result), .removed_entry_result(removed_entry_result),
        .exception(exception), .mm_cause(mm_cause), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp));
    rqh_mem_model u_rqh_mem_model (.clk(clk), .resetn(resetn), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    task automatic run(input rqh_variant_t v, input logic [63:0] h);
        int n = 0;
        @(negedge clk);
        start = 1'h1;
        variant = v;
        hdr = h;
        @(negedge clk);
        start = 1'h0;
        `CHK("busy", 1'h1, busy)
        // a second start with a misaligned header mid-run must be ignored
        while (done !== 1'h1 && n < 300)
        begin
            @(negedge clk);
            n++;
            start = (n == 2) && !done;
            hdr = (n == 2) ? h ^ 64'h4 : h;
        end
        `CHK("done", 1'h1, done)
    endtask : run

    // aligned long queue at H with a marker in the header back link
    task automatic setl(input logic [31:0] fh, input logic [31:0] fe);
        `MEM.m[H] = fh;
        `MEM.m[H + 64'h4] = 32'h5a5a5a58;
        `MEM.m[H + {32'h0, fh}] = fe;
    endtask : setl
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_empty;
        setl(32'h0, 32'h0);
        run(rqh_long_checked, H);
        `CHK("status", `RQH_STAT_EMPTY, status_result)
        `CHK("hdr_back", 32'h0, `MEM.rd(H + 64'h4))
        `CHK("hdr_fwd", 32'h0, `MEM.rd(H))
        $display("t_empty end");
    endtask : t_empty

    task automatic t_long(input rqh_variant_t v, input int l);
        `MEM.lat = l;
        setl(32'h40, 32'h40);
        run(v, H);
        `CHK("status", `RQH_STAT_MORE, status_result)
        `CHK("entry", H + 64'h40, removed_entry_result)
        `CHK("hdr_fwd", 32'h80, `MEM.rd(H))
        `CHK("back", 32'hffffff80, `MEM.rd(H + 64'h84))
        `CHK("hdr_back", 32'h5a5a5a58, `MEM.rd(H + 64'h4))
        `CHK("exc", rqh_exc_none, exception)
        $display("t_long %0d end", v);
    endtask : t_long

    task automatic t_quad;
        `MEM.lat = 1;
        `MEM.wr(Q, 64'h40, 1'h0);
        `MEM.wr(Q + 64'h8, 64'h7777777777777770, 1'h0);
        `MEM.wr(Q + 64'h40, 64'hffffffffffffffc0, 1'h0);
        run(rqh_quad_checked, Q);
        `CHK("status", `RQH_STAT_NOW_EMPTY, status_result)
        `CHK("entry", Q + 64'h40, removed_entry_result)
        `CHK("hdr_fwd", 64'h0, {`MEM.rd(Q + 64'h4), `MEM.rd(Q)})
        `CHK("back", 64'h0, {`MEM.rd(Q + 64'hc), `MEM.rd(Q + 64'h8)})
        `MEM.lat = 0;
        $display("t_quad end");
    endtask : t_quad

    task automatic t_lock;
        setl(32'h41, 32'h40);
        run(rqh_long_checked, H);
        `CHK("status", `RQH_STAT_BUSY, status_result)
        `CHK("hdr", 32'h41, `MEM.rd(H))
        setl(32'h40, 32'h40);
        `MEM.cond_fail = RETRY;
        run(rqh_long_checked, H);
        `CHK("status", `RQH_STAT_BUSY, status_result)
        `CHK("hdr", 32'h40, `MEM.rd(H))
        `MEM.cond_fail = RETRY - 8'h1;
        run(rqh_long_checked, H);
        `CHK("status", `RQH_STAT_MORE, status_result)
        $display("t_lock end");
    endtask : t_lock

    task automatic t_bad;
        rqh_variant_t v[3] = '{rqh_quad_checked, rqh_long_checked, rqh_long_checked};
        logic [63:0]  a[3] = '{64'h2008, 64'h1004, 64'h0000000100001000};
        logic [31:0]  fh[2] = '{32'h44, 32'h40};
        logic [31:0]  fe[2] = '{32'h0, 32'h44};
        rqh_mm_t      k[4] = '{rqh_mm_access_violation, rqh_mm_fault_on_read,
                               rqh_mm_fault_on_write, rqh_mm_translation_not_valid};
        for (int i = 0; i < 3; i++)
        begin
            run(v[i], a[i]);
            `CHK("exc", rqh_exc_illegal_operand, exception)
        end
        for (int i = 0; i < 2; i++)
        begin
            setl(fh[i], fe[i]);
            run(rqh_long_checked, H);
            `CHK("exc", rqh_exc_illegal_operand, exception)
            `CHK("hdr", fh[i], `MEM.rd(H))
        end
        for (int i = 0; i < 4; i++)
        begin
            `MEM.fault_kind = k[i];
            setl(32'h40, 32'h40);
            run(rqh_long_checked, H);
            `CHK("exc", rqh_exc_mm_fault, exception)
            `CHK("cause", k[i], mm_cause)
            `CHK("hdr", 32'h40, `MEM.rd(H))
        end
        `MEM.fault_kind = rqh_mm_ok;
        $display("t_bad end");
    endtask : t_bad
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'h1;
        t_empty();
        t_long(rqh_long_checked, 0);
        t_long(rqh_long_resident, 2);
        t_quad();
        t_lock();
        t_bad();
        results();
    end

    // the whole sequence needs well under two thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end
endmodule : rqh_remove_head_tb
